// >>> testbench/sbts_host_model.sv
/*
 * Far-side bus master (host or charger) for the supervisor bench.
 * Assumes open-drain lines resolved in the bench with pull-ups; it drives
 * only the low level and moves its lines just after a link clock edge.
 */
`timescale 1ns/1ps
module sbts_host_model (
    input  wire logic link_clk,    // Link clock
    input  wire logic scl,         // Resolved clock line
    output logic      scl_low,     // High pulls clock low
    output logic      sda_low      // High pulls data low
);
    // Lines released at start
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Start after bus free time, then first clock low
    task automatic start_c(input int half);
        repeat (60) @(posedge link_clk);
        sda_low <= 1'b1;
        repeat (half) @(posedge link_clk);
        scl_low <= 1'b1;
        repeat (half) @(posedge link_clk);
    endtask

    // One bit; waits while another party stretches the clock
    task automatic bit_c(input int half, input logic b);
        int n;
        n = 0;
        sda_low <= ~b;
        repeat (half) @(posedge link_clk);
        scl_low <= 1'b0;
        @(posedge link_clk);
        while (scl !== 1'b1 && n < 20000) begin
            @(posedge link_clk);
            n++;
        end
        repeat (half) @(posedge link_clk);
        scl_low <= 1'b1;
        repeat (half) @(posedge link_clk);
    endtask

    // Stop condition
    task automatic stop_c(input int half);
        sda_low <= 1'b1;
        repeat (half) @(posedge link_clk);
        scl_low <= 1'b0;
        repeat (half) @(posedge link_clk);
        sda_low <= 1'b0;
    endtask

    // Release clock only, leaving data low
    task automatic rel_c();
        @(posedge link_clk);
        scl_low <= 1'b0;
    endtask

    // Release data line, leaving the bus idle after an abort
    task automatic rel_d();
        @(posedge link_clk);
        sda_low <= 1'b0;
    endtask
endmodule

// >>> testbench/sbts_supervisor_tb.sv
/*
 * Self-checking bench for the bus timing supervisor.
 * Assumes the host model sits on the far side of the resolved lines.
 */
`timescale 1ns/1ps
module sbts_supervisor_tb;
    localparam int BUF_CYC  = 118;  // Bus free time in system cycles
    localparam int HALF_CYC = 244;  // Master half period
    localparam int HIGH_CYC = 1250; // Clock-high abort limit
    logic       ref_clk, link_clk, rst;
    logic       scl_oe, sda_oe, scl_o, sda_o, h_scl_low, h_sda_low;
    logic       hsel, pec_en, slv_st, mreq, mdone, mhold;
    logic [7:0] hset;
    logic       mbusy, mrise, pec_act, abort;
    sbts_pkg::sbts_stat_t stat;
    wire        scl = ~(scl_oe | h_scl_low); // Pull-up resolution
    wire        sda = ~(sda_oe | h_sda_low);
    int         n_fail, compares, aborts, cyc, h, n, a0;

    // Clocks, link one offset in phase
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;
    initial link_clk = 1'b0;
    always begin
        #13;
        forever #40 link_clk = ~link_clk;
    end

    sbts_supervisor dut_u (.REF_CLK_IN(ref_clk), .RESET_IN(rst), .LINK_CLK_IN(link_clk),
        .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o),
        .SDA_OE_OUT(sda_oe), .HIGH_PERIOD_SELECT_IN(hsel), .HIGH_PERIOD_SETTING_IN(hset),
        .PEC_ENABLE_IN(pec_en), .SLV_STRETCH_IN(slv_st), .MST_REQ_IN(mreq),
        .MST_DONE_IN(mdone), .MST_HOLD_IN(mhold), .MST_BUSY_OUT(mbusy),
        .MST_SCL_RISE_OUT(mrise), .PEC_ACTIVE_OUT(pec_act), .ABORT_OUT(abort),
        .STATUS_OUT(stat));

    sbts_host_model host_u (.link_clk(link_clk), .scl(scl), .scl_low(h_scl_low),
        .sda_low(h_sda_low));

    // Abort pulse counter and hang limit
    always @(posedge ref_clk) begin
        cyc++;
        if (abort === 1'b1) aborts++;
        if (cyc == 60000) begin
            n_fail++;
            end_sim();
        end
    end

    // Compare and report
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Condition chosen by code
    function automatic logic pick(input int w);
        case (w)
            0: return abort;
            1: return sda_oe;
            2: return scl_oe;
            3: return ~scl_oe;
            5: return mrise;
            default: return ~mbusy;
        endcase
    endfunction

    // Cycles until condition holds, bounded
    task automatic wait_for(input int w, input int lim, output int cnt);
        cnt = 0;
        while (pick(w) !== 1'b1 && cnt < lim) begin
            @(negedge ref_clk);
            cnt++;
        end
    endtask

    // Verdict
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        {rst, hsel, pec_en, slv_st, mreq, mdone, mhold} = 7'h40;
        hset = 8'h00;
        void'($urandom(28));
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        // Host transfers just below the fastest legal rate, then at a random legal rate
        for (int t = 0; t < 2; t++) begin
            h = (t == 0) ? 42 : 63 + $urandom_range(137);
            pec_en = 1'($urandom);
            a0 = aborts;
            host_u.start_c(h);
            repeat (10) @(negedge ref_clk);
            check("bus_busy", stat.bus_busy, 1);
            check("pec_active", pec_act, pec_en);
            repeat (9) host_u.bit_c(h, 1'($urandom));
            host_u.stop_c(h);
            repeat (10) @(negedge ref_clk);
            check("bus_busy_end", stat.bus_busy, 0);
            check("abort_count", aborts - a0, 0);
            $display("test host transfer half %0d done", h);
        end
        // Slave stretch holds the clock low
        host_u.start_c(63);
        @(negedge ref_clk);
        slv_st = 1'b1;
        repeat (10) @(negedge ref_clk);
        check("scl_oe_stretch", scl_oe, 1);
        fork
            host_u.bit_c(63, 1'b1);
            begin
                repeat (400) @(negedge ref_clk);
                check("scl_held", scl, 0);
                slv_st = 1'b0;
            end
        join
        host_u.stop_c(63);
        $display("test slave stretch done");
        // Clock-high abort, standard and programmed limit
        for (int s = 0; s < 2; s++) begin
            @(negedge ref_clk);
            hsel = s[0];
            hset = 8'h10 + 8'($urandom_range(40));
            a0 = (s == 0) ? HIGH_CYC : 25 * int'(hset);
            host_u.start_c(63);
            host_u.rel_c();
            wait_for(0, a0 + 200, n);
            check("high_abort_time", (n >= a0 - 4) && (n <= a0 + 20), 1);
            repeat (2) @(negedge ref_clk);
            check("high_abort_flag", stat.high_abort, 1);
            check("release", {stat.bus_busy, scl_oe, sda_oe}, 0);
            host_u.rel_d();
            repeat (100) @(negedge ref_clk);
            $display("test high abort select %0d done", s);
        end
        hsel = 1'b0;
        // Master transfer: free time from a stop, half periods, hold, stop
        host_u.start_c(63);
        host_u.stop_c(63);
        @(negedge ref_clk);
        pec_en = 1'($urandom);
        mreq = 1'b1;
        wait_for(1, 400, n);
        check("bus_free", (n >= BUF_CYC) && (n <= BUF_CYC + 12), 1);
        wait_for(2, 400, n);
        check("start_hold", (n >= HALF_CYC - 2) && (n <= HALF_CYC + 2), 1);
        check("pec_master", pec_act, pec_en);
        wait_for(3, 400, n);
        check("low_half", (n >= HALF_CYC - 2) && (n <= HALF_CYC + 2), 1);
        wait_for(2, 400, n);
        check("high_half", (n >= HALF_CYC - 2) && (n <= HALF_CYC + 2), 1);
        mhold = 1'b1;
        repeat (600) @(negedge ref_clk);
        check("hold_low", scl_oe, 1);
        mhold = 1'b0;
        mdone = 1'b1;
        wait_for(5, 400, n);
        check("rise_time", (n >= HALF_CYC - 2) && (n <= HALF_CYC + 2) && scl_oe, 1);
        @(negedge ref_clk);
        check("rise_after", {mrise, scl_oe}, 0);
        wait_for(4, 3000, n);
        check("master_idle", {mbusy, scl_oe, sda_oe, scl_o, sda_o}, 0);
        {mreq, mdone} = 2'h0;
        repeat (10) @(negedge ref_clk);
        check("status_end", stat, 0);
        $display("test master transfer done");
        end_sim();
    end
endmodule

// >>> verilog/sbts_defs.svh
/*
 * Timing constants for the two-wire bus timing supervisor.
 * Assumes a 25 MHz system clock; times are in their printed units.
 */
`ifndef SBTS_DEFS_SVH
`define SBTS_DEFS_SVH

// System clock in kHz
`define SBTS_CLK_KHZ          25000
// Slave clock range in kHz
`define SBTS_SLV_FMIN_KHZ     10
`define SBTS_SLV_FMAX_KHZ     100
// Master clock in Hz (51.2 kHz)
`define SBTS_MAS_F_HZ         51200
// Half period of master clock in cycles (rounded down)
`define SBTS_MAS_HALF_CYC     ((`SBTS_CLK_KHZ * 1000) / (2 * `SBTS_MAS_F_HZ))
// Margin over the pin-to-system sync delay, in system cycles
`define SBTS_SYNC_LAT_CYC     10
// Clock-low timeout, ms (min and max); detect at 30 ms
`define SBTS_TOUT_MIN_MS      25
`define SBTS_TOUT_MAX_MS      35
`define SBTS_TOUT_CYC         (((`SBTS_TOUT_MIN_MS + `SBTS_TOUT_MAX_MS) / 2) * `SBTS_CLK_KHZ)
// Clock-high abort, us
`define SBTS_HIGH_US          50
`define SBTS_HIGH_CYC         ((`SBTS_HIGH_US * `SBTS_CLK_KHZ) / 1000)
// High-period setting unit in cycles (one setting step is 1 us)
`define SBTS_HSET_UNIT_CYC    (`SBTS_CLK_KHZ / 1000)
// Slave cumulative stretch, ms
`define SBTS_SEXT_MS          25
`define SBTS_SEXT_CYC         (`SBTS_SEXT_MS * `SBTS_CLK_KHZ)
// Master cumulative extension, ms
`define SBTS_MEXT_MS          10
`define SBTS_MEXT_CYC         (`SBTS_MEXT_MS * `SBTS_CLK_KHZ)
// Bus free time, ns (4.7 us), rounded up
`define SBTS_BUF_NS           4700
`define SBTS_BUF_CYC          ((`SBTS_BUF_NS * `SBTS_CLK_KHZ + 999999) / 1000000)
// Bus-off entry, ms
`define SBTS_OFF_MS           2000
`define SBTS_OFF_CYC          (`SBTS_OFF_MS * `SBTS_CLK_KHZ)
// Resume after bus-off, us (at most 1 ms)
`define SBTS_RESUME_US        1000
`define SBTS_RESUME_CYC       ((`SBTS_RESUME_US * `SBTS_CLK_KHZ) / 1000)

`endif

// >>> verilog/sbts_pkg.sv
/*
 * Types for the two-wire bus timing supervisor.
 * Assumes sbts_defs.svh carries all numbers.
 */
package sbts_pkg;

    // Master engine states
    typedef enum logic [2:0] {
        MS_IDLE,
        MS_BUF,
        MS_START,
        MS_LOW,
        MS_HIGH,
        MS_STOP
    } sbts_mst_t;

    // Status carried out of the block
    typedef struct packed {
        logic bus_busy;
        logic bus_off;
        logic tout;
        logic high_abort;
        logic sext_err;
        logic mext_err;
    } sbts_stat_t;

    // Pin sample from the link domain
    typedef struct packed {
        logic scl;
        logic sda;
    } sbts_pins_t;

endpackage

// >>> verilog/sbts_supervisor.sv
/*
 * Bus timing supervisor: watches clock-low, clock-high, stretch budgets,
 * bus-off; runs a 51.2 kHz master clock generator with pec flag passed on.
 * Assumes open-drain pins resolved outside; link clock LINK_CLK_IN is the
 * 80 ns bench link clock, on which the pins are first sampled.
 */
`timescale 1ns/1ps
`include "sbts_defs.svh"

// Behaviour
// - Slave accepts 10 to 100 kHz clock
// - Master clock nominally 51.2 kHz
// - Clock low beyond timeout aborts transaction
// - Clock high over 50 us aborts
// - Select bit picks programmed high limit
// - Slave stretch per message at most 25 ms
// - Master extension per message at most 10 ms
// - Bus free 4.7 us stop to start
// - Both low 2 s gives bus-off
// - Master mode and optional packet-check flag passed on
module sbts_supervisor (
    // System clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        RESET_IN,
    // Link clock
    input  wire logic        LINK_CLK_IN,
    // Bus pins
    input  wire logic        SCL_IN,
    output logic             SCL_OUT,
    output logic             SCL_OE_OUT,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_OUT,
    // Configuration
    input  wire logic        HIGH_PERIOD_SELECT_IN,
    input  wire logic [7:0]  HIGH_PERIOD_SETTING_IN,
    input  wire logic        PEC_ENABLE_IN,
    // Slave engine stretch request
    input  wire logic        SLV_STRETCH_IN,
    // Master requests
    input  wire logic        MST_REQ_IN,
    input  wire logic        MST_DONE_IN,
    input  wire logic        MST_HOLD_IN,
    // Status
    output logic             MST_BUSY_OUT,
    output logic             MST_SCL_RISE_OUT,
    output logic             PEC_ACTIVE_OUT,
    output logic             ABORT_OUT,
    output sbts_pkg::sbts_stat_t STATUS_OUT
);

    // Link-domain samples and system-domain synchroniser
    sbts_pkg::sbts_pins_t    lnk_reg;           // Pin sample on link clock
    sbts_pkg::sbts_pins_t    lnk2_reg;          // Second link stage
    sbts_pkg::sbts_pins_t    sy1_reg;           // Crossing first stage
    sbts_pkg::sbts_pins_t    sy2_reg;           // Crossing second stage
    sbts_pkg::sbts_pins_t    prev_reg;          // Previous sample
    logic                    busy_reg;          // Message in progress
    logic [19:0]             low_cnt_reg;       // Single clock-low time
    logic [15:0]             high_cnt_reg;      // Clock-high time
    logic [19:0]             sext_cnt_reg;      // Slave stretch budget
    logic [18:0]             mext_cnt_reg;      // Master extension budget
    logic [25:0]             off_cnt_reg;       // Both-low time
    logic [15:0]             res_cnt_reg;       // Resume delay after bus-off
    logic                    off_reg;           // Bus-off state
    logic                    resume_reg;        // Waiting to resume
    logic [7:0]              buf_cnt_reg;       // Free time since stop
    logic [9:0]              mcnt_reg;          // Master half-period count
    sbts_pkg::sbts_mst_t     mst_reg;           // Master state
    logic                    mscl_reg;          // Master SCL drive low
    logic                    msda_reg;          // Master SDA drive low
    logic                    sstr_reg;          // Slave stretch drive
    sbts_pkg::sbts_stat_t    stat_reg;          // Status; error flags sticky for message
    logic                    abort_reg;         // Abort pulse
    logic                    pec_reg;           // Packet check latched
    logic                    start_det;         // Start condition
    logic                    stop_det;          // Stop condition
    logic                    tout_hit;          // Clock low too long
    logic                    high_hit;          // Clock high too long
    logic                    abort_now;         // Any abort cause
    logic [15:0]             high_lim;          // Selected high limit

    // Link-domain sampling: two flops on the link clock
    always_ff @(posedge LINK_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            lnk_reg  <= 2'h3;
            lnk2_reg <= 2'h3;
        end else begin
            lnk_reg  <= '{scl: SCL_IN, sda: SDA_IN};
            lnk2_reg <= lnk_reg;
        end
    end

    // Level crossing into the system domain
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sy1_reg  <= 2'h3;
            sy2_reg  <= 2'h3;
            prev_reg <= 2'h3;
        end else begin
            sy1_reg  <= lnk2_reg;
            sy2_reg  <= sy1_reg;
            prev_reg <= sy2_reg;
        end
    end

    // Start and stop detection while clock is high
    assign start_det = sy2_reg.scl && prev_reg.scl && prev_reg.sda && !sy2_reg.sda;
    assign stop_det  = sy2_reg.scl && prev_reg.scl && !prev_reg.sda && sy2_reg.sda;

    // High limit select
    assign high_lim = HIGH_PERIOD_SELECT_IN
                    ? 16'(HIGH_PERIOD_SETTING_IN * `SBTS_HSET_UNIT_CYC)
                    : 16'(`SBTS_HIGH_CYC);

    // Abort causes
    assign tout_hit  = (low_cnt_reg >= 20'(`SBTS_TOUT_CYC));
    assign high_hit  = busy_reg && (high_cnt_reg >= high_lim);
    assign abort_now = busy_reg && (tout_hit || high_hit
                     || sext_cnt_reg >= 20'(`SBTS_SEXT_CYC)
                     || mext_cnt_reg >= 19'(`SBTS_MEXT_CYC) || off_reg);

    // Message tracking; fresh start needed after abort
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            busy_reg  <= 1'b0;
            abort_reg <= 1'b0;
            pec_reg   <= 1'b0;
        end else begin
            abort_reg <= abort_now;
            if (abort_now || stop_det) begin
                busy_reg <= 1'b0;
            end else if (start_det && !off_reg) begin
                busy_reg <= 1'b1;
                pec_reg  <= PEC_ENABLE_IN;
            end
        end
    end

    // Clock-low and clock-high interval timers
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            low_cnt_reg  <= 20'h0;
            high_cnt_reg <= 16'h0;
        end else begin
            // Slave accepts any clock rate; timers only catch extremes
            low_cnt_reg  <= (sy2_reg.scl || !busy_reg) ? 20'h0
                          : (tout_hit ? low_cnt_reg : low_cnt_reg + 20'h1);
            high_cnt_reg <= (!sy2_reg.scl || !busy_reg || start_det) ? 16'h0
                          : (&high_cnt_reg ? high_cnt_reg : high_cnt_reg + 16'h1);
        end
    end

    // Cumulative stretch budgets for slave and master
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sext_cnt_reg <= 20'h0;
            mext_cnt_reg <= 19'h0;
        end else if (start_det && !busy_reg || !busy_reg) begin
            sext_cnt_reg <= 20'h0;
            mext_cnt_reg <= 19'h0;
        end else begin
            if (sstr_reg && !(&sext_cnt_reg))
                sext_cnt_reg <= sext_cnt_reg + 20'h1;
            if (mst_reg == sbts_pkg::MS_LOW && MST_HOLD_IN && !(&mext_cnt_reg))
                mext_cnt_reg <= mext_cnt_reg + 19'h1;
        end
    end

    // Slave stretch drive, cut at budget or abort
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sstr_reg <= 1'b0;
        end else begin
            sstr_reg <= SLV_STRETCH_IN && busy_reg && !abort_now && !sy2_reg.scl
                     && (sext_cnt_reg < 20'(`SBTS_SEXT_CYC) - 20'h1);
        end
    end

    // Bus-off detection and resume delay
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            off_cnt_reg <= 26'h0;
            off_reg     <= 1'b0;
            resume_reg  <= 1'b0;
            res_cnt_reg <= 16'h0;
        end else begin
            off_cnt_reg <= (sy2_reg.scl || sy2_reg.sda) ? 26'h0
                         : (off_reg ? off_cnt_reg : off_cnt_reg + 26'h1);
            if (off_cnt_reg >= 26'(`SBTS_OFF_CYC) - 26'h1) begin
                off_reg <= 1'b1;
            end else if (off_reg && (sy2_reg.scl || sy2_reg.sda)) begin
                off_reg     <= 1'b0;
                resume_reg  <= 1'b1;
                res_cnt_reg <= 16'h0;
            end else if (resume_reg) begin
                res_cnt_reg <= res_cnt_reg + 16'h1;
                if (res_cnt_reg >= 16'(`SBTS_RESUME_CYC) - 16'h2)
                    resume_reg <= 1'b0;
            end
        end
    end

    // Bus free counter since stop or idle
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            buf_cnt_reg <= 8'h0;
        end else if (busy_reg || !sy2_reg.scl || !sy2_reg.sda) begin
            buf_cnt_reg <= 8'h0;
        end else if (buf_cnt_reg != 8'hff) begin
            buf_cnt_reg <= buf_cnt_reg + 8'h1;
        end
    end

    // Master engine: 51.2 kHz clock generator
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            mst_reg  <= sbts_pkg::MS_IDLE;
            mcnt_reg <= 10'h0;
            mscl_reg <= 1'b0;
            msda_reg <= 1'b0;
        end else if (abort_now && mst_reg != sbts_pkg::MS_IDLE) begin
            mst_reg  <= sbts_pkg::MS_IDLE;
            mscl_reg <= 1'b0;
            msda_reg <= 1'b0;
        end else begin
            mcnt_reg <= mcnt_reg + 10'h1;
            case (mst_reg)
                sbts_pkg::MS_IDLE: begin
                    mcnt_reg <= 10'h0;
                    if (MST_REQ_IN && !off_reg && !resume_reg)
                        mst_reg <= sbts_pkg::MS_BUF;
                end
                sbts_pkg::MS_BUF: begin
                    mcnt_reg <= 10'h0;
                    if (busy_reg || off_reg)
                        mst_reg <= sbts_pkg::MS_IDLE;
                    else if (buf_cnt_reg >= 8'(`SBTS_BUF_CYC)) begin
                        msda_reg <= 1'b1;
                        mst_reg  <= sbts_pkg::MS_START;
                    end
                end
                sbts_pkg::MS_START: begin
                    if (mcnt_reg >= 10'(`SBTS_MAS_HALF_CYC) - 10'h1) begin
                        mcnt_reg <= 10'h0;
                        mscl_reg <= 1'b1;
                        mst_reg  <= sbts_pkg::MS_LOW;
                    end
                end
                sbts_pkg::MS_LOW: begin
                    if (MST_HOLD_IN) begin
                        mcnt_reg <= mcnt_reg;
                    end else if (mcnt_reg >= 10'(`SBTS_MAS_HALF_CYC) - 10'h1) begin
                        mcnt_reg <= 10'h0;
                        if (MST_DONE_IN) begin
                            msda_reg <= 1'b1;
                            mst_reg  <= sbts_pkg::MS_STOP;
                        end else begin
                            mst_reg <= sbts_pkg::MS_HIGH;
                        end
                        mscl_reg <= 1'b0;
                    end
                end
                sbts_pkg::MS_HIGH: begin
                    if (!sy2_reg.scl && mcnt_reg >= 10'(`SBTS_SYNC_LAT_CYC)) begin
                        mcnt_reg <= 10'(`SBTS_SYNC_LAT_CYC);             // Slave stretch
                    end else if (mcnt_reg >= 10'(`SBTS_MAS_HALF_CYC) - 10'h1) begin
                        mcnt_reg <= 10'h0;
                        mscl_reg <= 1'b1;
                        mst_reg  <= sbts_pkg::MS_LOW;
                    end
                end
                sbts_pkg::MS_STOP: begin
                    if (mcnt_reg >= 10'(`SBTS_MAS_HALF_CYC) - 10'h1) begin
                        msda_reg <= 1'b0;
                        mst_reg  <= sbts_pkg::MS_IDLE;
                    end
                end
                default: mst_reg <= sbts_pkg::MS_IDLE;
            endcase
        end
    end

    // Status per message; error flags sticky, set wins over start clear
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            stat_reg <= '0;
        end else begin
            stat_reg.bus_busy   <= busy_reg;
            stat_reg.bus_off    <= off_reg;
            stat_reg.tout       <= (busy_reg && tout_hit) || (stat_reg.tout && !start_det);
            stat_reg.high_abort <= high_hit || (stat_reg.high_abort && !start_det);
            stat_reg.sext_err   <= (busy_reg && sext_cnt_reg >= 20'(`SBTS_SEXT_CYC))
                                || (stat_reg.sext_err && !start_det);
            stat_reg.mext_err   <= (busy_reg && mext_cnt_reg >= 19'(`SBTS_MEXT_CYC))
                                || (stat_reg.mext_err && !start_det);
        end
    end

    // Pin drives: open drain, low only
    assign SCL_OUT          = 1'b0;
    assign SDA_OUT          = 1'b0;
    assign SCL_OE_OUT       = mscl_reg || sstr_reg;
    assign SDA_OE_OUT       = msda_reg;
    assign MST_BUSY_OUT     = (mst_reg != sbts_pkg::MS_IDLE);
    assign MST_SCL_RISE_OUT = (mst_reg == sbts_pkg::MS_LOW) && !MST_HOLD_IN
                            && (mcnt_reg >= 10'(`SBTS_MAS_HALF_CYC) - 10'h1);
    assign PEC_ACTIVE_OUT   = pec_reg;
    assign ABORT_OUT        = abort_reg;
    assign STATUS_OUT       = stat_reg;

    // Assertions
    AST_TOUT_ABORT: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        busy_reg && tout_hit |=> !busy_reg && abort_reg)
        else $error("Clock-low timeout did not abort");
    AST_HIGH_ABORT: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        busy_reg && !HIGH_PERIOD_SELECT_IN && high_cnt_reg >= 16'h4e2 |=> !busy_reg)
        else $error("Clock-high over limit did not abort");
    AST_HIGH_SEL: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        busy_reg && HIGH_PERIOD_SELECT_IN
        && high_cnt_reg >= 16'(HIGH_PERIOD_SETTING_IN) * 16'h19 |=> !busy_reg)
        else $error("High limit not from setting");
    AST_SEXT: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        sext_cnt_reg <= 20'(`SBTS_SEXT_CYC))
        else $error("Slave stretch over budget");
    AST_MEXT: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        mext_cnt_reg >= 19'(`SBTS_MEXT_CYC) && busy_reg |=> !busy_reg)
        else $error("Master extension not aborted");
    AST_BUF: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        $rose(msda_reg) && mst_reg == sbts_pkg::MS_START |-> $past(buf_cnt_reg) >= 8'h76)
        else $error("Start before bus free time");
    AST_OFF_DRIVE: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        off_reg |=> !mscl_reg && !msda_reg && !busy_reg)
        else $error("Driving during bus-off");
    AST_RELEASE: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        abort_now |=> !mscl_reg && !msda_reg && !sstr_reg)
        else $error("Lines held after abort");
    AST_MCLK: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
        $rose(mscl_reg) |-> mst_reg == sbts_pkg::MS_LOW && mcnt_reg == 10'h0)
        else $error("Master half period count not restarted");

endmodule
